// ### rtl/pas_top.sv
// pwm auto-shutdown stage with axi4-lite register slave
`timescale 1ns/1ps
`include "pas_map.svh"

// Behaviour
// [RL1] The event flag reads 0 while outputs run normally and 1 while they are held shut; here it reads 0 while held waiting for a period start.
// [RL2] A shutdown event sets the flag, which stays set until software or auto-restart clears it.
// [RL3] On a shutdown event the enabled pins take their shutdown states at once, without a clock.
// [RL4] The pins form pairs a/c and b/d, each with its own two-bit shutdown state field.
// [RL5] Source 000 disables, 001 comparator 1 high, 010 comparator 2 high, 011 either.
// [RL6] Sources 100-111 trigger on a low fault pin, adding comparator 1, 2 or either above 100.
// [RL7] A state field of 00 drives the pair low, 01 high, and 1x leaves it high impedance.
// [RL8] The trigger is a level and shutdown lasts as long as it stays active.
// [RL9] Software writes to the event flag are ignored while the trigger is active.
// [RL10] After restart the outputs resume only at the start of the next pwm period.
// [RL11] With auto-restart on, the flag clears itself once the trigger goes inactive.
module pas_top (
   input  wire logic                 ref_clk,
   input  wire logic                 reset_n,
   input  wire pas_pkg::pas_axi_req_t axi_req,
   output pas_pkg::pas_axi_rsp_t     axi_rsp,
   input  wire pas_pkg::pas_pins_t   pwm_in,
   input  wire logic                 period_start,
   input  wire logic                 fault_input_pin,
   input  wire logic                 comparator1_output,
   input  wire logic                 comparator2_output,
   output pas_pkg::pas_pins_t        pwm_out,
   output pas_pkg::pas_pins_t        pwm_oe_n,
   output logic                      irq
);
   import pas_pkg::*;

   //////////////////////////////////////////////////////////////////////
   // state and control storage
   logic                 shutdown_event_flag;
   logic [2:0]           shutdown_source_select;
   logic [1:0]           pair_ac_shutdown_state;
   logic [1:0]           pair_bd_shutdown_state;
   logic                 auto_restart;
   logic [1:0]           irq_status;
   logic [1:0]           irq_mask;
   logic [1:0]           next_irq_status;
   pas_state_t           state;
   pas_pins_t            run_q;
   logic                 trig;
   logic                 forced;
   logic                 aw_got;
   logic                 w_got;
   logic [7:0]           aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;
   logic                 wr_fire;
   logic                 wr_ctrl;
   logic                 ar_hs;
   logic                 ev_shut;
   logic                 ev_resume;
   logic [31:0]          rd_val;
   logic                 rd_ok;

   //////////////////////////////////////////////////////////////////////
   // helpers
   // trigger decode from source select and live inputs
   function automatic logic src_active(input logic [2:0] sel,
                                       input logic       flt_n,
                                       input logic       c1,
                                       input logic       c2);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         `PAS_SRC_OFF:     hit = 1'b0;
         `PAS_SRC_C1:      hit = c1;
         `PAS_SRC_C2:      hit = c2;
         `PAS_SRC_C12:     hit = c1 | c2;
         `PAS_SRC_FLT:     hit = ~flt_n;
         `PAS_SRC_FLT_C1:  hit = ~flt_n | c1;
         `PAS_SRC_FLT_C2:  hit = ~flt_n | c2;
         `PAS_SRC_FLT_C12: hit = ~flt_n | c1 | c2;
      endcase
      return hit;
   endfunction

   // pin level for a pair shutdown state
   function automatic logic ss_level(input logic [1:0] ss);
      return (ss == `PAS_SS_HIGH);
   endfunction

   // pin enable for a pair shutdown state, high means released
   function automatic logic ss_float(input logic [1:0] ss);
      return ss[`PAS_TRI_BIT];
   endfunction

   //////////////////////////////////////////////////////////////////////
   // trigger and forcing terms
   // level trigger straight from the pins
   assign trig = src_active(shutdown_source_select, fault_input_pin,
                            comparator1_output, comparator2_output); // RL5 RL6 RL8
   // forced while triggered, flagged or waiting for a period start
   assign forced = trig | shutdown_event_flag | (state != PAS_RUN); // RL1 RL8

   //////////////////////////////////////////////////////////////////////
   // pin outputs
   // normal pwm path, registered
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         run_q <= '0;
      end else begin
         run_q <= pwm_in;
      end
   end

   // shutdown override needs no edge, so it sits after the flop
   always_comb begin
      pwm_out  = run_q;
      pwm_oe_n = '0;
      if (forced) begin // RL3
         pwm_out.a  = ss_level(pair_ac_shutdown_state); // RL4 RL7
         pwm_out.c  = ss_level(pair_ac_shutdown_state); // RL4 RL7
         pwm_out.b  = ss_level(pair_bd_shutdown_state); // RL4 RL7
         pwm_out.d  = ss_level(pair_bd_shutdown_state); // RL4 RL7
         pwm_oe_n.a = ss_float(pair_ac_shutdown_state); // RL7
         pwm_oe_n.c = ss_float(pair_ac_shutdown_state); // RL7
         pwm_oe_n.b = ss_float(pair_bd_shutdown_state); // RL7
         pwm_oe_n.d = ss_float(pair_bd_shutdown_state); // RL7
      end
   end

   //////////////////////////////////////////////////////////////////////
   // output stage sequencer
   // run, shut, then wait for the period boundary before running
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= PAS_RUN;
      end else begin
         unique case (state)
            PAS_RUN: begin
               if (trig || shutdown_event_flag) begin
                  state <= PAS_SHUT;
               end
            end
            PAS_SHUT: begin
               if (!trig && !shutdown_event_flag) begin
                  state <= PAS_WAIT;
               end
            end
            PAS_WAIT: begin
               if (trig || shutdown_event_flag) begin
                  state <= PAS_SHUT;
               end else if (period_start) begin
                  state <= PAS_RUN; // RL10
               end
            end
         endcase
      end
   end

   assign ev_shut   = (state == PAS_RUN) && (trig || shutdown_event_flag);
   assign ev_resume = (state == PAS_WAIT) && period_start && !trig && !shutdown_event_flag;

   //////////////////////////////////////////////////////////////////////
   // event flag
   // trigger sets and wins; writes only land when trigger is gone
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         shutdown_event_flag <= 1'(`PAS_CTRL_RST >> `PAS_FLAG_BIT);
      end else if (trig) begin
         shutdown_event_flag <= 1'b1; // RL2 RL9
      end else if (wr_ctrl) begin
         shutdown_event_flag <= w_data[`PAS_FLAG_BIT]; // RL2
      end else if (auto_restart) begin
         shutdown_event_flag <= 1'b0; // RL11
      end
   end

   //////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   assign wr_fire = aw_got && w_got && !axi_rsp.bvalid;
   assign wr_ctrl = wr_fire && (aw_addr == `PAS_ADDR_CTRL) && w_strb[0];

   // address and data taken in either order, response after both
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         aw_got          <= 1'b0;
         w_got           <= 1'b0;
         aw_addr         <= '0;
         w_data          <= '0;
         w_strb          <= '0;
         axi_rsp.awready <= 1'b1;
         axi_rsp.wready  <= 1'b1;
         axi_rsp.bvalid  <= 1'b0;
         axi_rsp.bresp   <= `PAS_RESP_OKAY;
      end else begin
         if (axi_req.awvalid && axi_rsp.awready) begin
            aw_got          <= 1'b1;
            aw_addr         <= axi_req.awaddr[7:0];
            axi_rsp.awready <= 1'b0;
         end
         if (axi_req.wvalid && axi_rsp.wready) begin
            w_got          <= 1'b1;
            w_data         <= axi_req.wdata;
            w_strb         <= axi_req.wstrb;
            axi_rsp.wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_got         <= 1'b0;
            w_got          <= 1'b0;
            axi_rsp.bvalid <= 1'b1;
            unique case (aw_addr)
               `PAS_ADDR_CTRL, `PAS_ADDR_CFG, `PAS_ADDR_STAT, `PAS_ADDR_MASK:
                  axi_rsp.bresp <= `PAS_RESP_OKAY;
               default: axi_rsp.bresp <= `PAS_RESP_SLVERR;
            endcase
         end
         if (axi_rsp.bvalid && axi_req.bready) begin
            axi_rsp.bvalid  <= 1'b0;
            axi_rsp.awready <= 1'b1;
            axi_rsp.wready  <= 1'b1;
         end
      end
   end

   // configuration fields, flag kept apart above
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         shutdown_source_select <= 3'(`PAS_CTRL_RST >> `PAS_SRC_LO);
         pair_ac_shutdown_state <= 2'(`PAS_CTRL_RST >> `PAS_AC_LO);
         pair_bd_shutdown_state <= 2'(`PAS_CTRL_RST >> `PAS_BD_LO);
         auto_restart           <= 1'b0;
         irq_mask               <= `PAS_IRQ_RST;
      end else if (wr_fire && w_strb[0]) begin
         if (aw_addr == `PAS_ADDR_CTRL) begin
            shutdown_source_select <= w_data[`PAS_SRC_HI:`PAS_SRC_LO]; // RL5
            pair_ac_shutdown_state <= w_data[`PAS_AC_HI:`PAS_AC_LO]; // RL4
            pair_bd_shutdown_state <= w_data[`PAS_BD_HI:`PAS_BD_LO]; // RL4
         end
         if (aw_addr == `PAS_ADDR_CFG) begin
            auto_restart <= w_data[`PAS_CFG_AUTO];
         end
         if (aw_addr == `PAS_ADDR_MASK) begin
            irq_mask <= w_data[1:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   assign ar_hs = axi_req.arvalid && axi_rsp.arready;

   // read mux, unmapped reads zero
   always_comb begin
      rd_val = '0;
      rd_ok  = 1'b1;
      unique case (axi_req.araddr[7:0])
         `PAS_ADDR_CTRL: rd_val[7:0] = {shutdown_event_flag, shutdown_source_select,
                                        pair_ac_shutdown_state, pair_bd_shutdown_state}; // RL1
         `PAS_ADDR_CFG:  rd_val[`PAS_CFG_AUTO] = auto_restart;
         `PAS_ADDR_STAT: rd_val[1:0] = irq_status;
         `PAS_ADDR_MASK: rd_val[1:0] = irq_mask;
         default:        rd_ok = 1'b0;
      endcase
   end

   // one read at a time, data one cycle after the address
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         axi_rsp.arready <= 1'b1;
         axi_rsp.rvalid  <= 1'b0;
         axi_rsp.rdata   <= '0;
         axi_rsp.rresp   <= `PAS_RESP_OKAY;
      end else if (ar_hs) begin
         axi_rsp.arready <= 1'b0;
         axi_rsp.rvalid  <= 1'b1;
         axi_rsp.rdata   <= rd_val;
         axi_rsp.rresp   <= rd_ok ? `PAS_RESP_OKAY : `PAS_RESP_SLVERR;
      end else if (axi_rsp.rvalid && axi_req.rready) begin
         axi_rsp.rvalid  <= 1'b0;
         axi_rsp.arready <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // interrupts
   // read of status clears, a new event in that cycle wins
   always_comb begin
      next_irq_status = irq_status;
      if (ar_hs && (axi_req.araddr[7:0] == `PAS_ADDR_STAT)) begin
         next_irq_status = '0;
      end
      if (ev_shut) begin
         next_irq_status[`PAS_IRQ_SHUT] = 1'b1;
      end
      if (ev_resume) begin
         next_irq_status[`PAS_IRQ_RESUME] = 1'b1;
      end
   end

   // sticky status and masked level output
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irq_status <= `PAS_IRQ_RST;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         // a mask written this cycle counts at once, so irq never lags it
         irq        <= |(next_irq_status & ((wr_fire && w_strb[0] && aw_addr == `PAS_ADDR_MASK)
                                            ? w_data[1:0] : irq_mask));
      end
   end

   //////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_trig_held;
      trig [*2];
   endsequence

   sequence s_waiting;
      (state == PAS_WAIT) && !period_start && !trig && !shutdown_event_flag;
   endsequence

   a_flag_pins_shut: assert property ( // RL1
      shutdown_event_flag |-> forced && (state != PAS_RUN || $rose(shutdown_event_flag)
                                         || trig || !$past(reset_n)))
      else $error("flag set while outputs run");

   a_flag_sets: assert property ( // RL2
      trig |=> shutdown_event_flag)
      else $error("trigger did not set flag");

   a_flag_holds: assert property ( // RL2
      shutdown_event_flag && !trig && !auto_restart && !wr_ctrl |=> shutdown_event_flag)
      else $error("flag dropped without a clear");

   a_ac_drive_now: assert property ( // RL3
      trig && pair_ac_shutdown_state == `PAS_SS_LOW
      |-> !pwm_out.a && !pwm_out.c && !pwm_oe_n.a && !pwm_oe_n.c)
      else $error("pair ac not driven low on trigger");

   a_bd_drive_high: assert property ( // RL4
      trig && pair_bd_shutdown_state == `PAS_SS_HIGH
      |-> pwm_out.b && pwm_out.d && !pwm_oe_n.b && !pwm_oe_n.d)
      else $error("pair bd not driven high on trigger");

   a_src_comp_decode: assert property ( // RL5
      shutdown_source_select == `PAS_SRC_C12
      |-> trig == (comparator1_output || comparator2_output))
      else $error("comparator source decode wrong");

   a_src_off_decode: assert property ( // RL5
      shutdown_source_select == `PAS_SRC_OFF |-> !trig)
      else $error("disabled source still triggers");

   a_src_fault_pin: assert property ( // RL6
      shutdown_source_select[2] && !fault_input_pin |-> trig)
      else $error("low fault pin did not trigger");

   a_src_fault_c2: assert property ( // RL6
      shutdown_source_select == `PAS_SRC_FLT_C2 && fault_input_pin
      |-> trig == comparator2_output)
      else $error("fault plus comparator 2 decode wrong");

   a_pair_tristate: assert property ( // RL7
      trig && pair_ac_shutdown_state[`PAS_TRI_BIT] && pair_bd_shutdown_state[`PAS_TRI_BIT]
      |-> pwm_oe_n == 4'hf)
      else $error("pins not released in tri-state code");

   a_level_persist: assert property ( // RL8
      s_trig_held |-> state == PAS_SHUT && forced)
      else $error("shutdown ended under active trigger");

   a_write_ignored: assert property ( // RL9
      wr_ctrl && trig && !w_data[`PAS_FLAG_BIT] |=> shutdown_event_flag)
      else $error("flag write taken under trigger");

   a_resume_wait: assert property ( // RL10
      s_waiting |=> state != PAS_RUN)
      else $error("resumed before period start");

   a_resume_edge: assert property ( // RL10
      $rose(state == PAS_RUN) |-> $past(period_start))
      else $error("resume not on period start");

   a_auto_clear: assert property ( // RL11
      auto_restart && shutdown_event_flag && !trig && !wr_ctrl |=> !shutdown_event_flag)
      else $error("auto-restart did not clear flag");

   a_irq_level: assert property (
      (irq_status & irq_mask) != 2'h0 |-> irq)
      else $error("unmasked status without interrupt");

endmodule

// ### pkg/pas_map.svh
// register map, field positions and codes of the pwm auto-shutdown block
`ifndef PAS_MAP_SVH
`define PAS_MAP_SVH
`define PAS_ADDR_CTRL   8'h00
`define PAS_ADDR_CFG    8'h04
`define PAS_ADDR_STAT   8'h08
`define PAS_ADDR_MASK   8'h0c
`define PAS_FLAG_BIT    7
`define PAS_SRC_HI      6
`define PAS_SRC_LO      4
`define PAS_AC_HI       3
`define PAS_AC_LO       2
`define PAS_BD_HI       1
`define PAS_BD_LO       0
`define PAS_TRI_BIT     1
`define PAS_SRC_OFF     3'h0
`define PAS_SRC_C1      3'h1
`define PAS_SRC_C2      3'h2
`define PAS_SRC_C12     3'h3
`define PAS_SRC_FLT     3'h4
`define PAS_SRC_FLT_C1  3'h5
`define PAS_SRC_FLT_C2  3'h6
`define PAS_SRC_FLT_C12 3'h7
`define PAS_SS_LOW      2'h0
`define PAS_SS_HIGH     2'h1
`define PAS_CFG_AUTO    0
`define PAS_IRQ_SHUT    0
`define PAS_IRQ_RESUME  1
`define PAS_CTRL_RST    8'h00
`define PAS_IRQ_RST     2'h0
`define PAS_RESP_OKAY   2'h0
`define PAS_RESP_SLVERR 2'h2
`endif

// ### pkg/pas_pkg.sv
// types shared by the pwm auto-shutdown block
package pas_pkg;
   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } pas_axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pas_axi_rsp_t;
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } pas_pins_t;
   typedef enum logic [2:0] {
      PAS_RUN  = 3'b001,
      PAS_SHUT = 3'b010,
      PAS_WAIT = 3'b100
   } pas_state_t;
endpackage

// ### testbench/pas_far_side.sv
// model of the fault pin, both comparators and the pwm period timing
`timescale 1ns/1ps

module pas_far_side #(
   parameter int PERIOD = 8
) (
   input  wire logic ref_clk,
   input  wire logic fault_req,
   input  wire logic c1_req,
   input  wire logic c2_req,
   output logic      fault_input_pin,
   output logic      comparator1_output,
   output logic      comparator2_output,
   output logic      period_start
);
   int cnt = 0;

   // fault pin pulled low while a fault stands, comparators are plain levels
   assign fault_input_pin    = ~fault_req;
   assign comparator1_output = c1_req;
   assign comparator2_output = c2_req;

   // free running period counter, start pulse in the first cycle of each period
   always @(posedge ref_clk) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
   end
   assign period_start = (cnt == 0);
endmodule

// ### testbench/test_pwm_auto_shutdown.sv
// self-checking bench for the pwm auto-shutdown stage
`timescale 1ns/1ps
`include "pas_map.svh"

module test_pwm_auto_shutdown;
   import pas_pkg::*;
   logic         ref_clk   = 1'b0;
   logic         reset_n   = 1'b0;
   pas_axi_req_t req       = '0;
   pas_axi_rsp_t rsp;
   pas_pins_t    pwm_in    = 4'ha;
   pas_pins_t    pwm_out;
   pas_pins_t    pwm_oe_n;
   logic         irq;
   logic         period_start;
   logic         fault_input_pin;
   logic         comparator1_output;
   logic         comparator2_output;
   logic         fault_req = 1'b0;
   logic         c1_req    = 1'b0;
   logic         c2_req    = 1'b0;
   int           err_total = 0;
   int           checked   = 0;
   logic [31:0]  rd;
   logic [1:0]   rs;

   ////////////////////////////////////////////////////////////////////////////
   // clock, design and far side
   always #5 ref_clk = ~ref_clk;

   pas_top uut (
      .ref_clk            (ref_clk),
      .reset_n            (reset_n),
      .axi_req            (req),
      .axi_rsp            (rsp),
      .pwm_in             (pwm_in),
      .period_start       (period_start),
      .fault_input_pin    (fault_input_pin),
      .comparator1_output (comparator1_output),
      .comparator2_output (comparator2_output),
      .pwm_out            (pwm_out),
      .pwm_oe_n           (pwm_oe_n),
      .irq                (irq)
   );

   pas_far_side #(.PERIOD(8)) far (
      .ref_clk            (ref_clk),
      .fault_req          (fault_req),
      .c1_req             (c1_req),
      .c2_req             (c2_req),
      .fault_input_pin    (fault_input_pin),
      .comparator1_output (comparator1_output),
      .comparator2_output (comparator2_output),
      .period_start       (period_start)
   );

   ////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // axi write: address and data together, bready held until bvalid
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      req.awaddr  <= {24'h0, ad};
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
      rs = rsp.bresp;
   endtask

   // axi read: rready held until rvalid
   task automatic axi_rd(input logic [7:0] ad);
      @(posedge ref_clk);
      req.araddr  <= {24'h0, ad};
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      req.rready <= 1'b0;
      rd = rsp.rdata;
      rs = rsp.rresp;
   endtask

   // pins against forced states {ac, bd} or the normal pattern
   task automatic chk_pins(input logic forced, input logic [3:0] st);
      logic [3:0] oe;
      logic [3:0] v;
      oe = forced ? {st[3], st[1], st[3], st[1]} : 4'h0;
      v  = forced ? {st[2], st[0], st[2], st[0]} : 4'ha;
      chk("pins", {24'h0, oe, v & ~oe}, {24'h0, pwm_oe_n, pwm_out & ~oe});
   endtask

   // expected trigger from the select field
   function automatic logic trig(input logic [2:0] s, input logic f, input logic a,
                                 input logic b);
      return (s[2] & f) | (s[0] & a) | (s[1] & b);
   endfunction

   task automatic srcs(input logic f, input logic a, input logic b);
      @(posedge ref_clk);
      fault_req <= f;
      c1_req    <= a;
      c2_req    <= b;
   endtask

   // stage already waiting: pins held until a period start, then normal
   task automatic resume_wait(input logic [3:0] st);
      int n;
      @(posedge ref_clk);
      n = 0;
      while (!period_start && n < 40) begin
         #1 chk_pins(1'b1, st);
         @(posedge ref_clk);
         n++;
      end
      #1 chk_pins(1'b0, st);
   endtask

   // clear the flag, then resume at a period start
   task automatic restart(input logic [7:0] c, input logic [3:0] st);
      axi_wr(`PAS_ADDR_CTRL, {24'h0, c});
      resume_wait(st);
      axi_rd(`PAS_ADDR_CTRL);
      chk("ctrl after resume", {24'h0, c}, rd);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      axi_rd(`PAS_ADDR_CTRL);
      chk("ctrl reset", 32'h0, rd);
      #1 chk_pins(1'b0, 4'h0);
      axi_rd(8'h10);
      chk("unmapped rresp", {30'h0, `PAS_RESP_SLVERR}, {30'h0, rs});
      axi_wr(8'h14, 32'h1);
      chk("unmapped bresp", {30'h0, `PAS_RESP_SLVERR}, {30'h0, rs});
      $display("test reset done");
   endtask

   task automatic t_decode;
      logic e;
      for (int s = 0; s < 8; s++) begin
         for (int k = 0; k < 3; k++) begin
            axi_wr(`PAS_ADDR_CTRL, {24'h0, 1'b0, s[2:0], 4'h1});
            srcs(k == 0, k == 1, k == 2);
            e = trig(s[2:0], k == 0, k == 1, k == 2);
            #1 chk_pins(e, 4'h1);
            srcs(1'b0, 1'b0, 1'b0);
            if (e) begin
               axi_rd(`PAS_ADDR_CTRL);
               chk("flag sticky", {24'h0, 1'b1, s[2:0], 4'h1}, rd);
               restart({1'b0, s[2:0], 4'h1}, 4'h1);
            end
         end
      end
      $display("test decode done");
   endtask

   task automatic t_states;
      for (int st = 0; st < 16; st++) begin
         axi_wr(`PAS_ADDR_CTRL, {24'h0, 4'h8, st[3:0]});
         #1 chk_pins(1'b1, st[3:0]);
         restart({4'h0, st[3:0]}, st[3:0]);
      end
      $display("test states done");
   endtask

   task automatic t_level;
      axi_wr(`PAS_ADDR_CTRL, 32'h40);
      srcs(1'b1, 1'b0, 1'b0);
      repeat (6) begin
         @(posedge ref_clk);
         #1 chk_pins(1'b1, 4'h0);
      end
      axi_wr(`PAS_ADDR_CTRL, 32'h40);
      axi_rd(`PAS_ADDR_CTRL);
      chk("flag write blocked", 32'hc0, rd);
      srcs(1'b0, 1'b0, 1'b0);
      restart(8'h40, 4'h0);
      $display("test level done");
   endtask

   task automatic t_irq_auto;
      chk("irq masked", 32'h0, {31'h0, irq});
      axi_wr(`PAS_ADDR_MASK, 32'h3);
      @(posedge ref_clk);
      #1 chk("irq pending", 32'h1, {31'h0, irq});
      axi_rd(`PAS_ADDR_STAT);
      chk("status", 32'h3, rd);
      @(posedge ref_clk);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      axi_wr(`PAS_ADDR_CFG, 32'h1);
      axi_wr(`PAS_ADDR_CTRL, 32'h20);
      srcs(1'b0, 1'b0, 1'b1);
      #1 chk_pins(1'b1, 4'h0);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq shutdown", 32'h1, {31'h0, irq});
      axi_rd(`PAS_ADDR_CTRL);
      chk("flag set", 32'ha0, rd);
      srcs(1'b0, 1'b0, 1'b0);
      // flag clears by itself and the stage waits, no software write
      repeat (2) @(posedge ref_clk);
      resume_wait(4'h0);
      axi_rd(`PAS_ADDR_CTRL);
      chk("flag auto clear", 32'h20, rd);
      axi_rd(`PAS_ADDR_STAT);
      chk("status events", 32'h3, rd);
      axi_rd(`PAS_ADDR_CFG);
      chk("cfg readback", 32'h1, rd);
      $display("test irq auto done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // verdict, main sequence and watchdog
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_decode();
      t_states();
      t_level();
      t_irq_auto();
      final_report();
   end

   initial begin
      #200000;
      err_total++;
      final_report();
   end
endmodule
